// ==== rtl/serial_rx_test_cfg.svh ====
// Register indices, field positions, reset values and character codes for the
// serial receive test and error monitor. Assumes 32-bit Avalon-MM words, byte
// address equal to four times the register index.
`ifndef SERIAL_RX_TEST_CFG_SVH
`define SERIAL_RX_TEST_CFG_SVH

// ======
// Register indices (byte address is four times the index).
`define IDX_LINK_PAGE        11'h300
`define IDX_SAMPLE_CTRL      11'h32c
`define IDX_SAMPLE_EXP_LO    11'h32d
`define IDX_SAMPLE_EXP_HI    11'h32e
`define IDX_SAMPLE_RESULT    11'h32f
`define IDX_ERR_VIEW         11'h46b
`define IDX_DISP_CTRL        11'h46d
`define IDX_NIT_CTRL         11'h46e
`define IDX_UCC_CTRL         11'h46f
`define IDX_CGS_STATUS       11'h470
`define IDX_ALIGN_STATUS     11'h473
`define IDX_TEST_MODE        11'h477
`define IDX_ERR_IRQ          11'h47a
`define IDX_THRESHOLD        11'h47c
`define IDX_LANE_ENABLE      11'h47d

// ======
// Field positions.
`define BIT_LINK_PAGE        2
`define BIT_SAMPLE_EN        0
`define BIT_SAMPLE_RST       1
`define LSB_CONV_SEL         2
`define LSB_INDEX_SEL        4
`define BIT_SAMPLE_FAIL      0
`define LSB_VIEW_LANE        4
`define LSB_VIEW_TYPE        0
`define BIT_CLR_IRQ          7
`define BIT_DIS_CNT          6
`define BIT_CLR_CNT          5
`define LSB_CTRL_LANE        0
`define BIT_ALIGN_REPEAT     7
`define BIT_ERR_SYNC         0
`define LSB_IRQ_EN           5

// ======
// Reset values and constants.
`define RST_THRESHOLD        8'hff
`define RST_LANE_ENABLE      8'hff
`define PAGE1_LANE_OFFSET    3'h4
`define CHAR_COMMA           8'hbc
`define CHAR_ILAS_START      8'h1c
`define CHAR_ILAS_ALIGN      8'h7c
`define COMMA_RUN            3'h4

`endif

// ==== rtl/serial_rx_test_pkg.sv ====
// Types shared by the serial receive test and error monitor.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package serial_rx_test_pkg;

   // ======
   // One decoded character of a lane with its decoder error flags.
   typedef struct packed {
      logic [7:0] data;
      logic       isK;
      logic       dispErr;
      logic       nitErr;
      logic       uccErr;
   } lane_char_t;

   // Received samples of one frame, indexed by converter then sample.
   typedef logic [3:0][3:0][15:0] sample_frame_t;

   // Error counter types as coded in the counter-type field.
   typedef enum logic [1:0] {
      ERR_DISPARITY = 2'b00,
      ERR_NOT_TABLE = 2'b01,
      ERR_UNEXP_CTL = 2'b10
   } err_type_t;

endpackage

`default_nettype wire

// ==== rtl/serial_rx_test_and_error_monitor.sv ====
// Test and error monitor of a multi-lane serial receiver: sample checker,
// comma and alignment status, per-lane error counters, Avalon-MM slave.
// Assumes lane characters and samples come from decoder logic on mclk.
//
// Contract
// R1 - Compare the 16-bit expected sample with the selected received sample.
// R2 - Converter and sample index come from two-bit fields of test control.
// R3 - Sample checker works only while its enable bit is one.
// R4 - Checker reset bit pulsed by software clears the checker state.
// R5 - Read-only result bit: zero all matched, one a mismatch seen.
// R6 - Transmitter sends a distinct value per sample, repeated until stopped.
// R7 - Link synchronized, error-free, transmitter pattern on before checking.
// R8 - Report per-lane comma run synchronization in a status register.
// R9 - Repeated-alignment mode bit, set by software before link enable.
// R10 - Release active-low sync request after four commas on every enabled lane.
// R11 - In repeated mode the transmitter repeats the alignment sequence.
// R12 - One status bit per lane set when lane passes alignment.
// R13 - Page bit selects link 0 or link 1 for lane status and controls.
// R14 - Disparity counter counts every wrong-disparity character; here counting stops at the threshold and skips disabled lanes and counters.
// R15 - Detect three error types per lane; optionally raise a sync request. Unexpected control errors are ignored in repeated-alignment mode.
// R16 - Counter view register selects lane and type; its read returns count.
// R17 - Type code 00 disparity, 01 not-in-table, 10 unexpected control.
// R18 - Counters saturate at the programmable threshold.
// R19 - On link 1, link lane x means logical lane x plus four.
// R20 - One shared threshold; three per-type over-threshold flag registers.
// R21 - Control write on lane field: bit7 clear irq, bit6 disable, bit5 reset.
// R22 - Reads of control registers return over-threshold status.
// R23 - Per-type over-threshold interrupt enables with status readable there.
// R24 - Mismatch flag stays set until checker reset or disable.
//
// Design decision made here: register access over Avalon-MM.
`include "serial_rx_test_cfg.svh"
`default_nettype none

module serial_rx_test_and_error_monitor (
   input  wire logic                               mclk,
   input  wire logic                               srst,
   input  wire logic [12:0]                        address,
   input  wire logic                               read,
   input  wire logic                               write,
   input  wire logic [3:0]                         byteenable,
   input  wire logic [31:0]                        writedata,
   output logic      [31:0]                        readdata,
   output logic                                    waitrequest,
   input  wire serial_rx_test_pkg::lane_char_t [7:0] laneChar,
   input  wire logic                               sampleValid,
   input  wire serial_rx_test_pkg::sample_frame_t  sampleData,
   output logic                                    syncRequestOutN
);

   // ======
   // Declarations.
   logic [10:0] regIdx;
   logic        wrDo;
   logic [7:0]  wrByte;
   logic [7:0]  rdMux;
   logic [7:0]  sampleCtrl_r;
   logic [7:0]  expLo_r;
   logic [7:0]  expHi_r;
   logic        linkPage_r;
   logic        alignRepeat_r;
   logic        errSyncEn_r;
   logic [2:0]  irqEn_r;
   logic [7:0]  threshold_r;
   logic [7:0]  laneEnable_r;
   logic [2:0]  viewLane_r;
   logic [1:0]  viewType_r;
   logic        mismatch_r;
   logic [15:0] sampleSel;
   logic [7:0]  errCnt_r [3][8];
   logic [2:0][7:0] cntOff_r;
   logic [2:0][7:0] overIrq_r;
   logic [2:0][7:0] overFlag;
   logic [2:0][7:0] errHit;
   logic [2:0]  ctlType;
   logic [2:0]  ctlLane;
   logic [2:0]  cgsRun_r [8];
   logic [7:0]  cgsOk_r;
   logic [7:0]  ilasSeen_r;
   logic [7:0]  ilasOk_r;
   logic [7:0]  laneAnyErr;

   // Maps a link lane number to the logical lane for the selected page.
   function automatic logic [2:0] logicalLane(input logic page, input logic [2:0] sel);
      logicalLane = page ? sel + `PAGE1_LANE_OFFSET : sel;
   endfunction

   // Presents a per-lane vector for the selected link page.
   function automatic logic [7:0] pageView(input logic page, input logic [7:0] v);
      pageView = page ? {4'h0, v[7:4]} : v;
   endfunction

   // ======
   // Avalon-MM handshake: one wait cycle, then the access completes.
   assign regIdx = address[12:2];
   assign wrDo   = write && !waitrequest && byteenable[0];
   assign wrByte = writedata[7:0];

   // Waitrequest drops for exactly one cycle per request.
   always_ff @(posedge mclk) begin
      if (srst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // Read data is captured in the wait cycle and stands at the completing edge.
   always_ff @(posedge mclk) begin
      if (srst) begin
         readdata <= 32'h0;
      end else if (read && waitrequest) begin
         readdata <= {24'h0, rdMux};
      end
   end

   // ======
   // Read multiplexer; unmapped indices read as zero.
   always_comb begin
      rdMux = 8'h0;
      case (regIdx)
         `IDX_LINK_PAGE:     rdMux = {5'h0, linkPage_r, 2'h0};
         `IDX_SAMPLE_CTRL:   rdMux = sampleCtrl_r;
         `IDX_SAMPLE_EXP_LO: rdMux = expLo_r;
         `IDX_SAMPLE_EXP_HI: rdMux = expHi_r;
         `IDX_SAMPLE_RESULT: rdMux = {7'h0, mismatch_r}; // R5
         `IDX_ERR_VIEW: begin
            if (viewType_r == 2'b11) begin
               rdMux = 8'h0;
            end else begin
               rdMux = errCnt_r[viewType_r][logicalLane(linkPage_r, viewLane_r)]; // R16
            end
         end
         `IDX_DISP_CTRL:     rdMux = pageView(linkPage_r, overFlag[0]); // R22
         `IDX_NIT_CTRL:      rdMux = pageView(linkPage_r, overFlag[1]); // R20
         `IDX_UCC_CTRL:      rdMux = pageView(linkPage_r, overFlag[2]);
         `IDX_CGS_STATUS:    rdMux = pageView(linkPage_r, cgsOk_r); // R8
         `IDX_ALIGN_STATUS:  rdMux = pageView(linkPage_r, ilasOk_r); // R12
         `IDX_TEST_MODE:     rdMux = {alignRepeat_r, 6'h0, errSyncEn_r};
         `IDX_ERR_IRQ: begin
            rdMux = {irqEn_r & {|overIrq_r[0], |overIrq_r[1], |overIrq_r[2]}, 5'h0}; // R23
         end
         `IDX_THRESHOLD:     rdMux = threshold_r;
         `IDX_LANE_ENABLE:   rdMux = laneEnable_r;
         default:            rdMux = 8'h0;
      endcase
   end

   // ======
   // Software-written configuration registers.
   always_ff @(posedge mclk) begin
      if (srst) begin
         sampleCtrl_r  <= 8'h0;
         expLo_r       <= 8'h0;
         expHi_r       <= 8'h0;
         linkPage_r    <= 1'b0;
         alignRepeat_r <= 1'b0;
         errSyncEn_r   <= 1'b0;
         irqEn_r       <= 3'h0;
         threshold_r   <= `RST_THRESHOLD;
         laneEnable_r  <= `RST_LANE_ENABLE;
         viewLane_r    <= 3'h0;
         viewType_r    <= 2'h0;
      end else if (wrDo) begin
         case (regIdx)
            `IDX_LINK_PAGE:     linkPage_r <= wrByte[`BIT_LINK_PAGE]; // R13
            `IDX_SAMPLE_CTRL:   sampleCtrl_r <= wrByte; // R2
            `IDX_SAMPLE_EXP_LO: expLo_r <= wrByte;
            `IDX_SAMPLE_EXP_HI: expHi_r <= wrByte;
            `IDX_ERR_VIEW: begin
               viewLane_r <= wrByte[`LSB_VIEW_LANE +: 3]; // R16
               viewType_r <= wrByte[`LSB_VIEW_TYPE +: 2]; // R17
            end
            `IDX_TEST_MODE: begin
               alignRepeat_r <= wrByte[`BIT_ALIGN_REPEAT]; // R9
               errSyncEn_r   <= wrByte[`BIT_ERR_SYNC];
            end
            `IDX_ERR_IRQ:       irqEn_r <= wrByte[`LSB_IRQ_EN +: 3]; // R23
            `IDX_THRESHOLD:     threshold_r <= wrByte; // R18
            `IDX_LANE_ENABLE:   laneEnable_r <= wrByte;
            default: begin
            end
         endcase
      end
   end

   // ======
   // Sample checker: sticky mismatch while enabled and out of reset.
   assign sampleSel = sampleData[sampleCtrl_r[`LSB_CONV_SEL +: 2]]
                                [sampleCtrl_r[`LSB_INDEX_SEL +: 2]]; // R2

   // Mismatch holds until the checker is reset or disabled.
   always_ff @(posedge mclk) begin
      if (srst) begin
         mismatch_r <= 1'b0;
      end else if (!sampleCtrl_r[`BIT_SAMPLE_EN] || sampleCtrl_r[`BIT_SAMPLE_RST]) begin
         mismatch_r <= 1'b0; // R3 R4 R24
      end else if (sampleValid && (sampleSel != {expHi_r, expLo_r})) begin
         mismatch_r <= 1'b1; // R1 R24
      end
   end

   // ======
   // Error inputs per type and lane, and the shared threshold compare.
   always_comb begin
      for (int l = 0; l < 8; l++) begin
         errHit[0][l]  = laneEnable_r[l] && laneChar[l].dispErr; // R14
         errHit[1][l]  = laneEnable_r[l] && laneChar[l].nitErr; // R15
         errHit[2][l]  = laneEnable_r[l] && laneChar[l].uccErr && !alignRepeat_r;
         laneAnyErr[l] = errHit[0][l] || errHit[1][l] || errHit[2][l];
         for (int t = 0; t < 3; t++) begin
            overFlag[t][l] = errCnt_r[t][l] >= threshold_r; // R20
         end
      end
   end

   // Control register write decode: type from index, lane from the written lane field and page.
   always_comb begin
      ctlType = 3'h0;
      case (regIdx)
         `IDX_DISP_CTRL: ctlType = 3'b001;
         `IDX_NIT_CTRL:  ctlType = 3'b010;
         `IDX_UCC_CTRL:  ctlType = 3'b100;
         default:        ctlType = 3'h0;
      endcase
      ctlLane = logicalLane(linkPage_r, wrByte[`LSB_CTRL_LANE +: 3]); // R19
   end

   // ======
   // Per-lane, per-type saturating counters.
   always_ff @(posedge mclk) begin
      for (int t = 0; t < 3; t++) begin
         for (int l = 0; l < 8; l++) begin
            if (srst) begin
               errCnt_r[t][l] <= 8'h0;
            end else if (wrDo && ctlType[t] && (ctlLane == 3'(l))
                         && wrByte[`BIT_CLR_CNT]) begin
               errCnt_r[t][l] <= 8'h0; // R21
            end else if (errHit[t][l] && !cntOff_r[t][l]
                         && (errCnt_r[t][l] < threshold_r)) begin
               errCnt_r[t][l] <= errCnt_r[t][l] + 8'h01; // R18
            end
         end
      end
   end

   // Counter disables follow each control write to the addressed lane.
   always_ff @(posedge mclk) begin
      for (int t = 0; t < 3; t++) begin
         for (int l = 0; l < 8; l++) begin
            if (srst) begin
               cntOff_r[t][l] <= 1'b0;
            end else if (wrDo && ctlType[t] && (ctlLane == 3'(l))) begin
               cntOff_r[t][l] <= wrByte[`BIT_DIS_CNT]; // R21
            end
         end
      end
   end

   // Sticky over-threshold events; a new event wins over a clear.
   always_ff @(posedge mclk) begin
      for (int t = 0; t < 3; t++) begin
         for (int l = 0; l < 8; l++) begin
            if (srst) begin
               overIrq_r[t][l] <= 1'b0;
            end else if (overFlag[t][l]) begin
               overIrq_r[t][l] <= 1'b1;
            end else if (wrDo && ctlType[t] && (ctlLane == 3'(l))
                         && wrByte[`BIT_CLR_IRQ]) begin
               overIrq_r[t][l] <= 1'b0; // R21
            end
         end
      end
   end

   // ======
   // Comma run and alignment tracking per lane.
   always_ff @(posedge mclk) begin
      for (int l = 0; l < 8; l++) begin
         if (srst) begin
            cgsRun_r[l]   <= 3'h0;
            cgsOk_r[l]    <= 1'b0;
            ilasSeen_r[l] <= 1'b0;
            ilasOk_r[l]   <= 1'b0;
         end else if (!laneEnable_r[l] || (errSyncEn_r && laneAnyErr[l])) begin
            cgsRun_r[l]   <= 3'h0; // R15
            cgsOk_r[l]    <= 1'b0;
            ilasSeen_r[l] <= 1'b0;
            ilasOk_r[l]   <= 1'b0;
         end else if (!cgsOk_r[l]) begin
            if (laneChar[l].isK && (laneChar[l].data == `CHAR_COMMA)) begin
               cgsRun_r[l] <= cgsRun_r[l] + 3'h1;
               if (cgsRun_r[l] + 3'h1 == `COMMA_RUN) begin
                  cgsOk_r[l] <= 1'b1; // R8
               end
            end else begin
               cgsRun_r[l] <= 3'h0;
            end
         end else if (laneChar[l].isK && (laneChar[l].data == `CHAR_ILAS_START)) begin
            ilasSeen_r[l] <= 1'b1;
         end else if (ilasSeen_r[l] && laneChar[l].isK
                      && (laneChar[l].data == `CHAR_ILAS_ALIGN)) begin
            ilasOk_r[l] <= 1'b1; // R12 R11
         end
      end
   end

   // Sync request is released once every enabled lane has its comma run.
   always_ff @(posedge mclk) begin
      if (srst) begin
         syncRequestOutN <= 1'b0;
      end else begin
         syncRequestOutN <= (laneEnable_r != 8'h0) && (&(cgsOk_r | ~laneEnable_r)); // R10
      end
   end

endmodule

`default_nettype wire

// ==== dv/serial_rx_props.sv ====
// Checker for the serial receive test and error monitor.
// Assumes it is bound to the top module and sees only its ports.
`include "serial_rx_test_cfg.svh"
`default_nettype none
module serial_rx_props (
   input wire logic                                 mclk,
   input wire logic                                 srst,
   input wire logic [12:0]                          address,
   input wire logic                                 read,
   input wire logic                                 write,
   input wire logic [3:0]                           byteenable,
   input wire logic [31:0]                          writedata,
   input wire logic [31:0]                          readdata,
   input wire logic                                 waitrequest,
   input wire serial_rx_test_pkg::lane_char_t [7:0] laneChar,
   input wire logic                                 syncRequestOutN
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   // ======
   // Shadow copies of written registers, so reads can be judged.
   logic [10:0] idx;
   logic        rdOk;
   logic        allComma;
   logic [7:0]  thr_r;
   logic [7:0]  ctl_r;
   logic [1:0]  typ_r;
   assign idx = address[12:2];
   assign rdOk = read && !waitrequest;
   // Follows each completed write to the threshold, sample control and counter view registers.
   always_ff @(posedge mclk) begin
      if (srst) begin
         thr_r <= `RST_THRESHOLD;
         ctl_r <= 8'h00;
         typ_r <= 2'h0;
      end else if (write && !waitrequest && byteenable[0]) begin
         if (idx == `IDX_THRESHOLD) thr_r <= writedata[7:0];
         if (idx == `IDX_SAMPLE_CTRL) ctl_r <= writedata[7:0];
         if (idx == `IDX_ERR_VIEW) typ_r <= writedata[1:0];
      end
   end
   // Marks a cycle in which every lane carries a comma.
   always_comb begin
      allComma = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (!laneChar[i].isK || laneChar[i].data != `CHAR_COMMA) allComma = 1'b0;
      end
   end
   // ======
   // Properties.
   property p_ack; (read || write) && waitrequest |=> !waitrequest ##1 waitrequest; endproperty
   a_ack: assert property (p_ack) else $error("bus answer not one cycle");
   property p_upper; rdOk |-> readdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_resBits; rdOk && idx == `IDX_SAMPLE_RESULT |-> readdata[7:1] == 7'h0; endproperty
   a_resBits: assert property (p_resBits) else $error("result spare bits set");
   property p_resOff; rdOk && idx == `IDX_SAMPLE_RESULT && !ctl_r[0] |-> !readdata[0]; endproperty
   a_resOff: assert property (p_resOff) else $error("mismatch while disabled");
   property p_sat; rdOk && idx == `IDX_ERR_VIEW |-> readdata[7:0] <= thr_r; endproperty
   a_sat: assert property (p_sat) else $error("count above threshold");
   property p_type3; rdOk && idx == `IDX_ERR_VIEW && typ_r == 2'h3 |-> readdata[7:0] == 8'h0;
   endproperty
   a_type3: assert property (p_type3) else $error("unused counter type nonzero");
   property p_flags0;
      rdOk && thr_r == 8'h0 && idx inside {`IDX_DISP_CTRL, `IDX_NIT_CTRL, `IDX_UCC_CTRL}
      |-> readdata[3:0] == 4'hf;
   endproperty
   a_flags0: assert property (p_flags0) else $error("flags clear at zero threshold");
   property p_syncRel; allComma[*4] |=> ##1 syncRequestOutN; endproperty
   a_syncRel: assert property (p_syncRel) else $error("sync request not released");
   property p_syncWhy; $rose(syncRequestOutN) |-> $past(allComma, 2); endproperty
   a_syncWhy: assert property (p_syncWhy) else $error("sync released without commas");
endmodule
bind serial_rx_test_and_error_monitor serial_rx_props serial_rx_props_i (
   .mclk(mclk), .srst(srst), .address(address), .read(read), .write(write),
   .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .laneChar(laneChar), .syncRequestOutN(syncRequestOutN));
`default_nettype wire

// ==== dv/tx_lane_model.sv ====
// Behavioural transmitter feeding lane characters and sample frames.
// Assumes the bench sets mode and error mask by non-blocking assignment.
`include "serial_rx_test_cfg.svh"
`default_nettype none
module tx_lane_model (
   input  wire logic                                mclk,
   input  wire logic [1:0]                          mode,
   input  wire logic [7:0]                          errMask,
   input  wire logic [1:0]                          errKind,
   output var  serial_rx_test_pkg::lane_char_t [7:0] laneChar,
   output var  logic                                sampleValid,
   output var  serial_rx_test_pkg::sample_frame_t   sampleData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] step;
   // Every converter sample has its own value, repeated in every frame.
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 4; s++) sampleData[c][s] = 16'h5a00 + 16'(c * 16 + s);
      end
   end
   assign sampleValid = 1'b1;
   initial step = 3'h0;
   initial laneChar = '0;
   // Sends commas, a looping alignment sequence, or data with decoder errors.
   always @(posedge mclk) begin
      logic [7:0] d;
      logic       k;
      d = {5'h00, step};
      k = 1'b0;
      if (mode == 2'h1) begin
         d = `CHAR_COMMA;
         k = 1'b1;
      end else if (mode == 2'h2 && step == 3'h0) begin
         d = `CHAR_ILAS_START;
         k = 1'b1;
      end else if (mode == 2'h2 && step == 3'h7) begin
         d = `CHAR_ILAS_ALIGN;
         k = 1'b1;
      end
      step <= step + 3'h1;
      for (int i = 0; i < 8; i++) begin
         laneChar[i] <= '{d, k, errMask[i] && errKind[0] == errKind[1],
                          errMask[i] && errKind[0], errMask[i] && errKind == 2'h2};
      end
   end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the serial receive test and error monitor.
// Assumes the design, its checker and the transmitter model are compiled.
`include "serial_rx_test_cfg.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                                 mclk;
   logic                                 srst;
   logic [12:0]                          address;
   logic                                 read;
   logic                                 write;
   logic [31:0]                          writedata;
   logic [31:0]                          readdata;
   logic                                 waitrequest;
   serial_rx_test_pkg::lane_char_t [7:0] laneChar;
   logic                                 sampleValid;
   serial_rx_test_pkg::sample_frame_t    sampleData;
   logic                                 syncRequestOutN;
   logic [1:0]                           mode;
   logic [7:0]                           errMask;
   logic [1:0]                           errKind;
   int                                   miscompares;
   int                                   n_checks;
   int                                   cycles;
   serial_rx_test_and_error_monitor serial_rx_test_and_error_monitor_i (
      .mclk(mclk), .srst(srst), .address(address), .read(read), .write(write),
      .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .laneChar(laneChar), .sampleValid(sampleValid),
      .sampleData(sampleData), .syncRequestOutN(syncRequestOutN));
   tx_lane_model tx_lane_model_i (.mclk(mclk), .mode(mode), .errMask(errMask),
      .errKind(errKind), .laneChar(laneChar), .sampleValid(sampleValid),
      .sampleData(sampleData));
   // ======
   // Clock, timeout and shared tasks.
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Cuts a hang short.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus access, held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [10:0] idx, input logic [7:0] d);
      address <= {idx, 2'b00};
      writedata <= {24'h0, d};
      read <= !wr;
      write <= wr;
      @(posedge mclk);
      while (waitrequest !== 1'b0) @(posedge mclk);
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd_chk(input string what, input logic [10:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check(what, readdata, {24'h0, exp});
   endtask
   task automatic view_chk(input string what, input logic [2:0] ln, input logic [1:0] ty,
                           input logic [7:0] exp);
      bus(1'b1, `IDX_ERR_VIEW, {1'b0, ln, 2'b00, ty});
      rd_chk(what, `IDX_ERR_VIEW, exp);
   endtask
   task automatic inject(input logic [1:0] kind, input logic [7:0] lanes, input int n);
      errKind <= kind;
      errMask <= lanes;
      repeat (n) @(posedge mclk);
      errMask <= 8'h00;
      repeat (3) @(posedge mclk);
   endtask
   function automatic logic [15:0] sval(input int c, input int s);
      return 16'h5a00 + 16'(c * 16 + s);
   endfunction
   task automatic sample_case(input logic [1:0] c, input logic [1:0] s, input logic [15:0] v,
                              input logic [7:0] exp);
      bus(1'b1, `IDX_SAMPLE_CTRL, {2'b00, s, c, 2'b00});
      bus(1'b1, `IDX_SAMPLE_EXP_LO, v[7:0]);
      bus(1'b1, `IDX_SAMPLE_EXP_HI, v[15:8]);
      bus(1'b1, `IDX_SAMPLE_CTRL, {2'b00, s, c, 2'b01});
      bus(1'b1, `IDX_SAMPLE_CTRL, {2'b00, s, c, 2'b11});
      bus(1'b1, `IDX_SAMPLE_CTRL, {2'b00, s, c, 2'b01});
      rd_chk("sample result", `IDX_SAMPLE_RESULT, exp);
   endtask
   // ======
   // Scenarios.
   task automatic t_reset();
      check("sync after reset", {31'h0, syncRequestOutN}, 32'h0);
      rd_chk("threshold", `IDX_THRESHOLD, `RST_THRESHOLD);
      rd_chk("unmapped", 11'h100, 8'h00);
      bus(1'b1, `IDX_THRESHOLD, 8'h00);
      rd_chk("flags at zero", `IDX_UCC_CTRL, 8'hff);
      bus(1'b1, `IDX_THRESHOLD, `RST_THRESHOLD);
      rd_chk("flags clear", `IDX_NIT_CTRL, 8'h00);
   endtask
   task automatic t_link();
      mode <= 2'h1;
      repeat (6) @(posedge mclk);
      check("sync early", {31'h0, syncRequestOutN}, 32'h0);
      @(posedge mclk);
      check("sync released", {31'h0, syncRequestOutN}, 32'h1);
      rd_chk("comma status", `IDX_CGS_STATUS, 8'hff);
      bus(1'b1, `IDX_LINK_PAGE, 8'h04);
      rd_chk("comma link 1", `IDX_CGS_STATUS, 8'h0f);
      bus(1'b1, `IDX_LINK_PAGE, 8'h00);
      bus(1'b1, `IDX_TEST_MODE, 8'h80);
      bus(1'b1, `IDX_LANE_ENABLE, `RST_LANE_ENABLE);
      mode <= 2'h2;
      repeat (20) @(posedge mclk);
      rd_chk("alignment", `IDX_ALIGN_STATUS, 8'hff);
      mode <= 2'h0;
      bus(1'b1, `IDX_TEST_MODE, 8'h00);
   endtask
   task automatic t_sample();
      sample_case(2'h0, 2'h0, sval(0, 0), 8'h00);
      sample_case(2'h2, 2'h1, sval(2, 1) ^ 16'h8000, 8'h01);
      sample_case(2'h3, 2'h2, sval(3, 2), 8'h00);
      sample_case(2'h1, 2'h3, sval(1, 2), 8'h01);
      bus(1'b1, `IDX_SAMPLE_EXP_LO, 8'h13);
      rd_chk("mismatch held", `IDX_SAMPLE_RESULT, 8'h01);
      bus(1'b1, `IDX_SAMPLE_CTRL, 8'h00);
      rd_chk("disabled", `IDX_SAMPLE_RESULT, 8'h00);
   endtask
   task automatic t_errors();
      bus(1'b1, `IDX_THRESHOLD, 8'h03);
      for (int k = 0; k < 3; k++) begin
         inject(2'(k), 8'h02, 5);
         view_chk("count", 3'h1, 2'(k), 8'h03);
         rd_chk("over flag", `IDX_DISP_CTRL + 11'(k), 8'h02);
      end
      view_chk("unused type", 3'h1, 2'h3, 8'h00);
      rd_chk("irq masked", `IDX_ERR_IRQ, 8'h00);
      bus(1'b1, `IDX_ERR_IRQ, 8'he0);
      rd_chk("irq status", `IDX_ERR_IRQ, 8'he0);
      inject(2'h3, 8'h04, 2);
      view_chk("disparity off table", 3'h2, 2'h0, 8'h02);
      bus(1'b1, `IDX_DISP_CTRL, 8'h21);
      view_chk("cleared", 3'h1, 2'h0, 8'h00);
      bus(1'b1, `IDX_DISP_CTRL, 8'h41);
      inject(2'h0, 8'h02, 2);
      view_chk("disabled", 3'h1, 2'h0, 8'h00);
      bus(1'b1, `IDX_DISP_CTRL, 8'h01);
      inject(2'h0, 8'h20, 2);
      bus(1'b1, `IDX_LINK_PAGE, 8'h04);
      view_chk("link 1 lane 1", 3'h1, 2'h0, 8'h02);
      bus(1'b1, `IDX_LINK_PAGE, 8'h00);
   endtask
   // Main sequence.
   initial begin
      srst = 1'b1;
      address = 13'h0000;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      mode = 2'h0;
      errMask = 8'h00;
      errKind = 2'h0;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_link();
      t_sample();
      t_errors();
      wrap_up();
   end
endmodule
`default_nettype wire
